// file: logic/uets_map.svh
// register map, field positions and counts for the transmit status block
`ifndef UETS_MAP_SVH
`define UETS_MAP_SVH

`define UETS_TX_ENDPOINT_STATUS_ADDR 8'h0C
`define UETS_INDEX_ADDR  8'h20
`define UETS_MISC_ADDR   8'h21
`define UETS_RDY_LO_ADDR 8'h22
`define UETS_RDY_HI_ADDR 8'h23

`define UETS_BYTE_RESET  8'h00
`define UETS_BIT_TOG     7
`define UETS_BIT_DSAM    6
`define UETS_BIT_NAKE    5
`define UETS_BIT_FLUSH   4
`define UETS_BIT_OVW     3
`define UETS_BIT_VOID    2
`define UETS_BIT_ERR     1
`define UETS_BIT_ACK     0
`define UETS_BIT_ENHANCED_BEHAVIOR_SELECT    0
`define UETS_BIT_BDFT    1

`define UETS_CNT_ZERO    2'h0
`define UETS_CNT_ONE     2'h1
`define UETS_CNT_FULL    2'h2
`define UETS_MAX_EP      16
`define UETS_BYTE_BITS   8

`endif

// file: logic/uets_pkg.sv
// types shared by the transmit status block
package uets_pkg;
	typedef logic [1:0] uets_cnt_t;
	typedef logic [7:0] uets_byte_t;
endpackage : uets_pkg

// file: logic/uets_set_queue.sv
// per-endpoint data set queue with isochronous frame hiding and flush
`timescale 1ns/100ps
`include "uets_map.svh"

module uets_set_queue
	import uets_pkg::*;
(
	input  wire logic      clock_i,
	input  wire logic      rst_i,
	input  wire logic      iso_i,
	input  wire logic      enh_i,
	input  wire logic      write_i,
	input  wire logic      read_i,
	input  wire logic      in_seen_i,
	input  wire logic      sof_i,
	output uets_cnt_t      host_sets_o,
	output logic           drop_o
);
	uets_cnt_t tot_q;
	uets_cnt_t tot_d;
	uets_cnt_t hid_q;
	uets_cnt_t hid_d;
	logic      seen_q;
	logic      drop_d;
	uets_cnt_t vis;

	// sets hidden until the next frame are not offered to the host
	assign vis = tot_q - hid_q;
	assign host_sets_o = vis;
	assign drop_o = drop_d;

	// next queue state; a flush at start of frame precedes a new write
	always_comb
	begin
		tot_d = tot_q;
		hid_d = hid_q;
		drop_d = 1'b0;
		if (read_i && vis != `UETS_CNT_ZERO)
			tot_d = tot_d - `UETS_CNT_ONE;
		if (sof_i && iso_i)
		begin
			if (!enh_i)
			begin
				if (tot_q == `UETS_CNT_FULL && !seen_q && !read_i)
				begin
					drop_d = 1'b1;
					tot_d = tot_d - `UETS_CNT_ONE;
				end
			end
			else
			begin
				if (vis != `UETS_CNT_ZERO && !read_i)
				begin
					drop_d = 1'b1;
					tot_d = tot_d - `UETS_CNT_ONE;
				end
				if (hid_q == `UETS_CNT_FULL)
				begin
					drop_d = 1'b1;
					tot_d = tot_d - `UETS_CNT_ONE;
				end
				hid_d = `UETS_CNT_ZERO;
			end
		end
		if (write_i && tot_d != `UETS_CNT_FULL)
		begin
			tot_d = tot_d + `UETS_CNT_ONE;
			if (iso_i && enh_i)
				hid_d = hid_d + `UETS_CNT_ONE;
		end
	end

	// queue counters
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			tot_q <= `UETS_CNT_ZERO;
			hid_q <= `UETS_CNT_ZERO;
		end
		else
		begin
			tot_q <= tot_d;
			hid_q <= hid_d;
		end
	end

	// remembers whether the host asked for data during this frame
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			seen_q <= 1'b0;
		else if (sof_i)
			seen_q <= 1'b0;
		else if (in_seen_i)
			seen_q <= 1'b1;
	end
endmodule : uets_set_queue

// file: logic/uets_top.sv
// endpoint-indexed transmit status register with toggle and void logic
`timescale 1ns/100ps
`include "uets_map.svh"

// How it works
// - Send current toggle in next IN data PID; invert on valid ACK.
// - Invert the transmit toggle on every valid SETUP token.
// - Toggle changes by firmware only when written with overwrite bit set.
// - Toggle overwrite bit always reads back as zero.
// - Available mode: empty-FIFO NAK sets ready bit and gated output pin.
// - NAK interrupt mode: empty-FIFO NAK sets void and interrupt bit.
// - All enhancement bits clear gives the earlier compatible behaviour.
// - Flushed flag rewritten at every start of frame.
// - Legacy mode: two isochronous sets, no IN in frame, oldest dropped.
// - Enhanced: writes count at once, isochronous sets show next frame.
// - Enhanced: unread or older isochronous set flushed at frame start.
// - Without NAK mode void is read-only and tracks void causes.
// - Void updated at transaction end, isochronous at next clean frame.
// - Void never touches done interrupt, error or acknowledge flags.
// - NAK mode: void writable, hardware set wins and raises interrupt.
// - Missing handshake or underrun flags error and transmit done.
// - Acknowledged transmission flags acknowledge and transmit done.
// - Error and acknowledge update together, exactly one set.
// - Isochronous error and acknowledge deferred to clean frame start.
// - Status register indexed by endpoint select, resets to zero.
module uets_top
	import uets_pkg::*;
#(
	parameter int NUM_EP = `UETS_MAX_EP,
	parameter int EPW    = $clog2(NUM_EP)
)
(
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	input  wire logic [7:0]        addr_i,
	input  wire logic [7:0]        wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic [7:0]             rdata_o,
	input  wire logic [EPW-1:0]    sie_ep_i,
	input  wire logic              in_token_i,
	input  wire logic              setup_token_i,
	input  wire logic              tx_end_i,
	input  wire logic              tx_data_i,
	input  wire logic              tx_acked_i,
	input  wire logic              tx_underrun_i,
	input  wire logic              sof_i,
	input  wire logic              set_write_i,
	input  wire logic [EPW-1:0]    set_write_ep_i,
	input  wire logic [NUM_EP-1:0] iso_ep_i,
	input  wire logic [NUM_EP-1:0] transmit_output_allow_i,
	input  wire logic [NUM_EP-1:0] transmit_halt_i,
	input  wire logic [NUM_EP-1:0] setup_packet_pending_i,
	input  wire logic [NUM_EP-1:0] fifo_underrun_flag_i,
	input  wire logic [NUM_EP-1:0] fifo_overrun_flag_i,
	output logic                   tx_data_toggle_o,
	output uets_cnt_t              host_sets_o,
	output logic                   set_ready_output_pin_o,
	output logic [NUM_EP-1:0]      endpoint_irq_set_o,
	output logic [NUM_EP-1:0]      transmit_done_irq_bit_o
);
	uets_byte_t          rdata_q;
	logic [EPW-1:0]      index_q;
	logic                enhanced_behavior_select_q;
	logic                bdft_q;
	logic                pin_q;
	logic [NUM_EP-1:0]   tog_q;
	logic [NUM_EP-1:0]   dsam_q;
	logic [NUM_EP-1:0]   nake_q;
	logic [NUM_EP-1:0]   flush_q;
	logic [NUM_EP-1:0]   void_q;
	logic [NUM_EP-1:0]   err_q;
	logic [NUM_EP-1:0]   ack_q;
	logic [NUM_EP-1:0]   rdy_q;
	logic [NUM_EP-1:0]   vcond_q;
	logic [NUM_EP-1:0]   pvoid_q;
	logic [NUM_EP-1:0]   pvv_q;
	logic [NUM_EP-1:0]   perr_q;
	logic [NUM_EP-1:0]   pev_q;
	logic [NUM_EP-1:0]   nirq_q;
	logic [NUM_EP-1:0]   dirq_q;
	logic [NUM_EP-1:0]   drop;
	uets_byte_t          stat_w [NUM_EP];
	uets_cnt_t           sets_w [NUM_EP];
	logic [15:0]         rdy16;
	logic                err_v;

	// an error wins when a handshake is missing or the FIFO ran dry
	assign err_v = !tx_acked_i || tx_underrun_i;

	assign rdata_o = rdata_q;
	assign set_ready_output_pin_o = pin_q;
	assign endpoint_irq_set_o = nirq_q;
	assign transmit_done_irq_bit_o = dirq_q;
	assign tx_data_toggle_o = tog_q[sie_ep_i];
	assign host_sets_o = sets_w[sie_ep_i];

	// endpoint select, feature and board bits
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			index_q <= '0;
			enhanced_behavior_select_q <= 1'b0;
			bdft_q <= 1'b0;
		end
		else if (wr_i && addr_i == `UETS_INDEX_ADDR)
			index_q <= wdata_i[EPW-1:0];
		else if (wr_i && addr_i == `UETS_MISC_ADDR)
		begin
			enhanced_behavior_select_q <= wdata_i[`UETS_BIT_ENHANCED_BEHAVIOR_SELECT];
			bdft_q <= wdata_i[`UETS_BIT_BDFT];
		end
	end

	// pin is registered so it never glitches on the ready-bit update
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			pin_q <= 1'b0;
		else
			pin_q <= bdft_q && (|rdy_q);
	end

	// ready bits spread over two bytes, unused positions read as zero
	for (genvar j = 0; j < `UETS_MAX_EP; j++)
	begin : g_rdy
		if (j < NUM_EP)
		begin : g_used
			assign rdy16[j] = rdy_q[j];
		end
		else
		begin : g_pad
			assign rdy16[j] = 1'b0;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			rdata_q <= `UETS_BYTE_RESET;
		else if (!rd_i)
			rdata_q <= `UETS_BYTE_RESET;
		else if (addr_i == `UETS_TX_ENDPOINT_STATUS_ADDR)
			rdata_q <= stat_w[index_q];
		else if (addr_i == `UETS_INDEX_ADDR)
			rdata_q <= uets_byte_t'(index_q);
		else if (addr_i == `UETS_MISC_ADDR)
			rdata_q <= uets_byte_t'({bdft_q, enhanced_behavior_select_q});
		else if (addr_i == `UETS_RDY_LO_ADDR)
			rdata_q <= rdy16[7:0];
		else if (addr_i == `UETS_RDY_HI_ADDR)
			rdata_q <= rdy16[15:8];
		else
			rdata_q <= `UETS_BYTE_RESET;
	end

	for (genvar i = 0; i < NUM_EP; i++)
	begin : g_ep
		localparam int RBYTE = i / `UETS_BYTE_BITS;
		localparam int RBIT  = i % `UETS_BYTE_BITS;
		logic hit;
		logic ev_in;
		logic ev_end;
		logic st_wr;
		logic void_cond;
		logic nak_empty;
		logic sof_ok;
		logic rdy_clr;

		assign hit = sie_ep_i == EPW'(i);
		assign ev_in = in_token_i && hit;
		assign ev_end = tx_end_i && hit;
		assign st_wr = wr_i && addr_i == `UETS_TX_ENDPOINT_STATUS_ADDR &&
			index_q == EPW'(i);
		assign void_cond = !transmit_output_allow_i[i] ||
			transmit_halt_i[i] || setup_packet_pending_i[i] ||
			sets_w[i] == `UETS_CNT_ZERO || fifo_underrun_flag_i[i] ||
			fifo_overrun_flag_i[i];
		// a NAK that only the empty FIFO explains
		assign nak_empty = transmit_output_allow_i[i] &&
			!transmit_halt_i[i] && !setup_packet_pending_i[i] &&
			!fifo_underrun_flag_i[i] && !fifo_overrun_flag_i[i] &&
			sets_w[i] == `UETS_CNT_ZERO;
		// a frame start that did not drop a stale set
		assign sof_ok = sof_i && iso_ep_i[i] && !drop[i];
		assign rdy_clr = wr_i && wdata_i[RBIT] &&
			((addr_i == `UETS_RDY_LO_ADDR && RBYTE == 0) ||
			(addr_i == `UETS_RDY_HI_ADDR && RBYTE == 1));

		assign stat_w[i] = {tog_q[i], dsam_q[i], nake_q[i], flush_q[i],
			1'b0, void_q[i], err_q[i], ack_q[i]};

		uets_set_queue u_queue (
			.clock_i     (clock_i),
			.rst_i       (rst_i),
			.iso_i       (iso_ep_i[i]),
			.enh_i       (enhanced_behavior_select_q),
			.write_i     (set_write_i && set_write_ep_i == EPW'(i)),
			.read_i      (ev_end && tx_data_i &&
				(tx_acked_i || iso_ep_i[i])),
			.in_seen_i   (ev_in),
			.sof_i       (sof_i),
			.host_sets_o (sets_w[i]),
			.drop_o      (drop[i])
		);
		// hardware toggle events outrank a firmware overwrite
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
				tog_q[i] <= 1'b0;
			else if ((setup_token_i && hit) ||
				(ev_end && tx_data_i && tx_acked_i))
				tog_q[i] <= ~tog_q[i];
			else if (st_wr && wdata_i[`UETS_BIT_OVW])
				tog_q[i] <= wdata_i[`UETS_BIT_TOG];
		end
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
			begin
				dsam_q[i] <= 1'b0;
				nake_q[i] <= 1'b0;
			end
			else if (st_wr)
			begin
				dsam_q[i] <= wdata_i[`UETS_BIT_DSAM];
				nake_q[i] <= wdata_i[`UETS_BIT_NAKE];
			end
		end
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
				flush_q[i] <= 1'b0;
			else if (sof_i)
				flush_q[i] <= drop[i];
		end
		// void cause is sampled at the token, applied later
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
				vcond_q[i] <= 1'b0;
			else if (ev_in)
				vcond_q[i] <= void_cond;
		end
		// isochronous void result waits for the next frame start
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
			begin
				pvoid_q[i] <= 1'b0;
				pvv_q[i] <= 1'b0;
			end
			else if (ev_end && iso_ep_i[i])
			begin
				pvoid_q[i] <= vcond_q[i];
				pvv_q[i] <= 1'b1;
			end
			else if (sof_i)
				pvv_q[i] <= 1'b0;
		end
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
				void_q[i] <= 1'b0;
			else if (nake_q[i])
			begin
				if (ev_in && nak_empty)
					void_q[i] <= 1'b1;
				else if (st_wr)
					void_q[i] <= wdata_i[`UETS_BIT_VOID];
			end
			else if (ev_end && !iso_ep_i[i])
				void_q[i] <= vcond_q[i];
			else if (sof_ok && pvv_q[i])
				void_q[i] <= pvoid_q[i];
		end

		// isochronous result held until the frame start
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
			begin
				perr_q[i] <= 1'b0;
				pev_q[i] <= 1'b0;
			end
			else if (ev_end && tx_data_i && iso_ep_i[i])
			begin
				perr_q[i] <= err_v;
				pev_q[i] <= 1'b1;
			end
			else if (sof_i)
				pev_q[i] <= 1'b0;
		end

		// error and acknowledge always move as a pair
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
			begin
				err_q[i] <= 1'b0;
				ack_q[i] <= 1'b0;
			end
			else if (ev_end && tx_data_i && !iso_ep_i[i])
			begin
				err_q[i] <= err_v;
				ack_q[i] <= !err_v;
			end
			else if (sof_ok && pev_q[i])
			begin
				err_q[i] <= perr_q[i];
				ack_q[i] <= !perr_q[i];
			end
		end

		// done pulse follows each error or acknowledge update
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
				dirq_q[i] <= 1'b0;
			else
				dirq_q[i] <= (ev_end && tx_data_i && !iso_ep_i[i]) ||
					(sof_ok && pev_q[i]);
		end

		// interrupt pulse only in NAK interrupt mode
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
				nirq_q[i] <= 1'b0;
			else
				nirq_q[i] <= nake_q[i] && ev_in && nak_empty;
		end

		// ready bit: set beats a write-one clear in the same cycle
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
				rdy_q[i] <= 1'b0;
			else if (dsam_q[i] && ev_in && nak_empty)
				rdy_q[i] <= 1'b1;
			else if (rdy_clr)
				rdy_q[i] <= 1'b0;
		end
	end
endmodule : uets_top

// file: verification/uets_monitor.sv
// port checker for the transmit status block
`timescale 1ns/100ps
`include "uets_map.svh"
module uets_monitor
	import uets_pkg::*;
#(
	parameter int NUM_EP = 16,
	parameter int EPW    = 4
)
(
	input wire logic              clock_i,
	input wire logic              rst_i,
	input wire logic [7:0]        addr_i,
	input wire logic              rd_i,
	input wire logic [7:0]        rdata_o,
	input wire logic [EPW-1:0]    sie_ep_i,
	input wire logic              in_token_i,
	input wire logic              setup_token_i,
	input wire logic              tx_end_i,
	input wire logic              tx_data_i,
	input wire logic              tx_acked_i,
	input wire logic              sof_i,
	input wire logic [NUM_EP-1:0] iso_ep_i,
	input wire logic              tx_data_toggle_o,
	input wire uets_cnt_t         host_sets_o,
	input wire logic [NUM_EP-1:0] endpoint_irq_set_o,
	input wire logic [NUM_EP-1:0] transmit_done_irq_bit_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// bus answers, toggle flips and pulse causes, each tied to its event
	property p_rd_idle;
		!$past(rd_i) |-> rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_ovw_zero;
		$past(rd_i) && $past(addr_i) == `UETS_TX_ENDPOINT_STATUS_ADDR |-> !rdata_o[3];
	endproperty
	a_ovw_zero: assert property (p_ovw_zero) else $error("overwrite read 1");
	property p_ack_flip;
		tx_end_i && tx_data_i && tx_acked_i ##1 $stable(sie_ep_i)
			|-> tx_data_toggle_o != $past(tx_data_toggle_o);
	endproperty
	a_ack_flip: assert property (p_ack_flip) else $error("no flip on ack");
	property p_setup_flip;
		setup_token_i ##1 $stable(sie_ep_i)
			|-> tx_data_toggle_o != $past(tx_data_toggle_o);
	endproperty
	a_setup_flip: assert property (p_setup_flip) else $error("no setup flip");
	property p_done;
		tx_end_i && tx_data_i && !iso_ep_i[sie_ep_i]
			|=> transmit_done_irq_bit_o[$past(sie_ep_i)];
	endproperty
	a_done: assert property (p_done) else $error("missing done pulse");
	property p_iso_defer;
		tx_end_i && iso_ep_i[sie_ep_i] && !sof_i
			|=> !transmit_done_irq_bit_o[$past(sie_ep_i)];
	endproperty
	a_iso_defer: assert property (p_iso_defer) else $error("iso not deferred");
	property p_done_cause;
		|transmit_done_irq_bit_o |-> $past(tx_end_i) || $past(sof_i);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("done no cause");
	property p_void_irq;
		|endpoint_irq_set_o |-> $past(in_token_i) && $past(host_sets_o) == 2'h0;
	endproperty
	a_void_irq: assert property (p_void_irq) else $error("bad void pulse");
endmodule : uets_monitor

bind uets_top uets_monitor #(.NUM_EP(NUM_EP), .EPW(EPW)) u_uets_monitor (.*);

// file: verification/uets_host.sv
// host model issuing tokens, handshakes and frame starts
`timescale 1ns/100ps
module uets_host
#(
	parameter int EPW = 4
)
(
	input  wire logic      clock_i,
	output logic [EPW-1:0] ep_o,
	output logic           in_token_o,
	output logic           setup_token_o,
	output logic           tx_end_o,
	output logic           tx_data_o,
	output logic           tx_acked_o,
	output logic           tx_underrun_o,
	output logic           sof_o
);
	// quiet bus at time zero
	initial
	begin
		ep_o = '0;
		{in_token_o, setup_token_o, tx_end_o, sof_o} = 4'h0;
		{tx_data_o, tx_acked_o, tx_underrun_o} = 3'h0;
	end
	// token, then end of transaction one cycle later
	task automatic in_txn(input logic [EPW-1:0] ep, input logic [2:0] dau);
		@(posedge clock_i);
		ep_o <= ep;
		in_token_o <= 1'h1;
		@(posedge clock_i);
		in_token_o <= 1'h0;
		tx_end_o <= 1'h1;
		{tx_data_o, tx_acked_o, tx_underrun_o} <= dau;
		@(posedge clock_i);
		tx_end_o <= 1'h0;
		// released qualifiers show junk so stale values are never trusted
		{tx_data_o, tx_acked_o, tx_underrun_o} <= ~dau;
	endtask : in_txn
	// one-cycle setup token or frame start
	task automatic pulse(input logic [EPW-1:0] ep, input logic is_sof);
		@(posedge clock_i);
		ep_o <= ep;
		sof_o <= is_sof;
		setup_token_o <= ~is_sof;
		@(posedge clock_i);
		{sof_o, setup_token_o} <= 2'h0;
	endtask : pulse
endmodule : uets_host

// file: verification/testbench.sv
// self-checking bench for the transmit status block
`timescale 1ns/100ps
`include "uets_map.svh"
module testbench;
	import uets_pkg::*;
	localparam int NUM_EP = 4;
	localparam int EPW    = 2;
	logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, set_write_i = 0, tog = 0;
	logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, st;
	logic [EPW-1:0] set_write_ep_i = 0, sie_ep_i;
	logic [NUM_EP-1:0] iso_ep_i = 0, transmit_output_allow_i = 4'hF;
	logic [NUM_EP-1:0] transmit_halt_i = 0, setup_packet_pending_i = 0;
	logic [NUM_EP-1:0] fifo_underrun_flag_i = 0, fifo_overrun_flag_i = 0;
	logic [NUM_EP-1:0] endpoint_irq_set_o, transmit_done_irq_bit_o;
	logic [NUM_EP-1:0] irq_acc = 0, done_acc = 0;
	logic in_token_i, setup_token_i, tx_end_i, tx_data_i, tx_acked_i;
	logic tx_underrun_i, sof_i, tx_data_toggle_o, set_ready_output_pin_o;
	logic [2:0] c;
	uets_cnt_t host_sets_o;
	int num_errors = 0, num_checks = 0;
	// write set, void cause, data/ack/underrun, expected void/err/ack
	logic [9:0] rows [10] = '{10'h231, 10'h222, 10'h02A, 10'h046, 10'h086,
		10'h0C6, 10'h106, 10'h146, 10'h031, 10'h005};
	uets_top #(.NUM_EP(NUM_EP)) u_uets_top (.*);
	uets_host #(.EPW(EPW)) u_uets_host (.clock_i(clock_i), .ep_o(sie_ep_i),
		.in_token_o(in_token_i), .setup_token_o(setup_token_i),
		.tx_end_o(tx_end_i), .tx_data_o(tx_data_i), .tx_acked_o(tx_acked_i),
		.tx_underrun_o(tx_underrun_i), .sof_o(sof_i));
	always #2 clock_i = ~clock_i;
	// pulses are one cycle wide, so keep them until the bench looks
	always @(posedge clock_i)
	begin
		irq_acc |= endpoint_irq_set_o;
		done_acc |= transmit_done_irq_bit_o;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
			num_errors++;
		if (got !== exp)
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge clock_i);
		wr_i <= 1'h0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clock_i);
		rd_i <= 1'h0;
		#1 st = rdata_o;
	endtask : rd_reg
	task automatic put_set(input logic [EPW-1:0] ep);
		@(posedge clock_i);
		set_write_i <= 1'h1;
		set_write_ep_i <= ep;
		@(posedge clock_i);
		set_write_i <= 1'h0;
	endtask : put_set
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	initial
	begin
		#20000;
		num_errors++;
		end_of_test();
	end
	initial
	begin
		repeat (2) @(posedge clock_i);
		rst_i <= 1'h0;
		wr_reg(`UETS_INDEX_ADDR, 8'h01);
		foreach (rows[i])
		begin
			@(posedge clock_i);
			c = rows[i][8:6];
			transmit_output_allow_i <= (c == 3'h1) ? 4'hD : 4'hF;
			transmit_halt_i <= (c == 3'h2) ? 4'h2 : 4'h0;
			setup_packet_pending_i <= (c == 3'h3) ? 4'h2 : 4'h0;
			fifo_underrun_flag_i <= (c == 3'h4) ? 4'h2 : 4'h0;
			fifo_overrun_flag_i <= (c == 3'h5) ? 4'h2 : 4'h0;
			if (rows[i][9])
				put_set(2'h1);
			u_uets_host.in_txn(2'h1, rows[i][5:3]);
			tog ^= rows[i][5] & rows[i][4];
			rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
			chk(st[2:0], rows[i][2:0]);
			chk(st[7], tog);
			chk(done_acc[1], rows[i][5]);
			done_acc = '0;
		end
		wr_reg(`UETS_TX_ENDPOINT_STATUS_ADDR, {~tog, 7'h00});
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk(st[7], tog);
		wr_reg(`UETS_TX_ENDPOINT_STATUS_ADDR, {~tog, 7'h28});
		tog = ~tog;
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk(st, {tog, 7'h25});
		u_uets_host.pulse(2'h1, 1'h0);
		tog = ~tog;
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk(st[7], tog);
		wr_reg(`UETS_TX_ENDPOINT_STATUS_ADDR, 8'h20);
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk(st[2], 8'h00);
		irq_acc = '0;
		u_uets_host.in_txn(2'h1, 3'h0);
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk(st, {tog, 7'h25});
		chk({irq_acc[1], done_acc[1]}, 8'h02);
		wr_reg(`UETS_MISC_ADDR, 8'h02);
		wr_reg(`UETS_TX_ENDPOINT_STATUS_ADDR, 8'h40);
		u_uets_host.in_txn(2'h1, 3'h0);
		rd_reg(`UETS_RDY_LO_ADDR);
		chk({st[6:0], set_ready_output_pin_o}, 8'h05);
		wr_reg(`UETS_RDY_LO_ADDR, 8'h02);
		rd_reg(`UETS_RDY_LO_ADDR);
		chk({st[6:0], set_ready_output_pin_o}, 8'h00);
		// hardware set beats a firmware clear in one cycle
		wr_reg(`UETS_TX_ENDPOINT_STATUS_ADDR, 8'h20);
		wr_reg(`UETS_TX_ENDPOINT_STATUS_ADDR, 8'h20);
		irq_acc = '0;
		fork
			u_uets_host.in_txn(2'h1, 3'h0);
			wr_reg(`UETS_TX_ENDPOINT_STATUS_ADDR, 8'h20);
		join
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk(st, {tog, 7'h25});
		chk(irq_acc[1], 8'h01);
		wr_reg(`UETS_TX_ENDPOINT_STATUS_ADDR, 8'h00);
		wr_reg(`UETS_MISC_ADDR, 8'h00);
		// modes stay clear on the isochronous endpoint
		iso_ep_i <= 4'h4;
		wr_reg(`UETS_INDEX_ADDR, 8'h02);
		put_set(2'h2);
		put_set(2'h2);
		u_uets_host.pulse(2'h2, 1'h1);
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk({st[4], host_sets_o}, 8'h05);
		u_uets_host.pulse(2'h2, 1'h1);
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk({st[4], host_sets_o}, 8'h01);
		done_acc = '0;
		u_uets_host.in_txn(2'h2, 3'h4);
		repeat (2) @(posedge clock_i);
		chk(done_acc[2], 8'h00);
		u_uets_host.pulse(2'h2, 1'h1);
		repeat (2) @(posedge clock_i);
		chk(done_acc[2], 8'h01);
		wr_reg(`UETS_MISC_ADDR, 8'h01);
		rd_reg(`UETS_MISC_ADDR);
		chk(st, 8'h01);
		rd_reg(`UETS_INDEX_ADDR);
		chk(st, 8'h02);
		rd_reg(`UETS_RDY_HI_ADDR);
		chk(st, 8'h00);
		put_set(2'h2);
		#1 chk(host_sets_o, 8'h00);
		u_uets_host.pulse(2'h2, 1'h1);
		#1 chk(host_sets_o, 8'h01);
		u_uets_host.pulse(2'h2, 1'h1);
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk({st[4], host_sets_o}, 8'h04);
		// a flushing frame start skips the pending result
		put_set(2'h2);
		u_uets_host.pulse(2'h2, 1'h1);
		u_uets_host.in_txn(2'h2, 3'h6);
		put_set(2'h2);
		put_set(2'h2);
		done_acc = '0;
		u_uets_host.pulse(2'h2, 1'h1);
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk({st[4], st[1:0], host_sets_o}, 8'h19);
		chk(done_acc[2], 8'h00);
		@(posedge clock_i);
		rst_i <= 1'h1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'h0;
		rd_reg(`UETS_TX_ENDPOINT_STATUS_ADDR);
		chk(st, 8'h00);
		chk({tx_data_toggle_o, host_sets_o}, 8'h00);
		end_of_test();
	end
endmodule : testbench
